// ---- dir_reg.sv ----
`timescale 1ns/10ps
module dir_reg #(
   parameter int          WIDTH = 8,
   parameter logic [7:0]  RESET = 8'hff
)
(
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   // Load
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] din,
   output      logic [WIDTH-1:0] q
);
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         q <= RESET[WIDTH-1:0];
      else if (load)
         q <= din;
   end
endmodule

// ---- exec_pkg.sv ----
package exec_pkg;
   typedef enum logic [1:0]
   {
      NIBBLE_EXCHANGE_OP      = 2'h0,
      XOR_IMMEDIATE_OP        = 2'h1,
      XOR_MEMORY_OP           = 2'h2,
      PORT_DIRECTION_LOAD_OP  = 2'h3
   } op_type;

   localparam logic [7:0] ACC_RESET      = 8'h00;
   localparam logic [7:0] DIR_RESET      = 8'hff;
   localparam logic [6:0] MEM_ADDR_MAX   = 7'h7f;
   localparam logic [2:0] PORT_A_SEL     = 3'h5;
   localparam logic [2:0] PORT_B_SEL     = 3'h6;
   localparam logic [2:0] PORT_C_SEL     = 3'h7;
   localparam logic       DEST_ACC       = 1'b0;
   localparam logic       DEST_MEM       = 1'b1;
endpackage

// ---- mem_model.sv ----
`timescale 1ns/10ps
module mem_model
(
   // Clock
   input  wire logic       clk_sys,
   // Read port
   input  wire logic [6:0] rdAddr,
   output      logic [7:0] rdData,
   // Write port
   input  wire logic       we,
   input  wire logic [6:0] wAddr,
   input  wire logic [7:0] wData
);
   logic [7:0] mem [128];
   initial
   begin
      for (int i = 0; i < 128; i++)
         mem[i] = 8'(i);
   end
   // Combinational read, write lands on the edge after the strobe
   assign rdData = mem[rdAddr];
   always @(posedge clk_sys)
   begin
      if (we)
         mem[wAddr] <= wData;
   end
endmodule

// ---- nibble_swap_xor_port_direction_load_op_exec.sv ----
`timescale 1ns/10ps
module nibble_swap_xor_port_direction_load_op_exec #(
   parameter int DATA_W = 8
)
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              resetn,
   // Instruction from decode
   input  wire logic              opValid,
   input  wire exec_pkg::op_type  opCode,
   input  wire logic [6:0]        operandAddr,
   input  wire logic              destSel,
   input  wire logic [7:0]        literal,
   // Data memory read data for operandAddr
   input  wire logic [7:0]        memRdata,
   // Data memory write back
   output      logic              memWe_r,
   output      logic [6:0]        memWaddr_r,
   output      logic [7:0]        memWdata_r,
   // Core state
   output      logic [7:0]        acc_r,
   output      logic              zeroFlag_r,
   // Port direction registers
   output      logic [7:0]        port_a_direction,
   output      logic [7:0]        port_b_direction,
   output      logic [7:0]        port_c_direction
);
   logic [7:0] result;
   logic       toMem;
   logic       loadA;
   logic       loadB;
   logic       loadC;

   always_comb
   begin
      result = 8'h00;
      toMem  = 1'b0;
      unique case (opCode)
         exec_pkg::NIBBLE_EXCHANGE_OP:
         begin
            result = {memRdata[3:0], memRdata[7:4]};
            toMem  = (destSel == exec_pkg::DEST_MEM);
         end
         exec_pkg::XOR_IMMEDIATE_OP:
         begin
            result = acc_r ^ literal;
         end
         exec_pkg::XOR_MEMORY_OP:
         begin
            result = acc_r ^ memRdata;
            toMem  = (destSel == exec_pkg::DEST_MEM);
         end
         exec_pkg::PORT_DIRECTION_LOAD_OP:
         begin
            result = acc_r;
         end
      endcase
   end

   wire logic isDir = opValid && (opCode == exec_pkg::PORT_DIRECTION_LOAD_OP);
   assign loadA = isDir && (operandAddr[2:0] == exec_pkg::PORT_A_SEL) && (operandAddr[6:3] == 4'h0);
   assign loadB = isDir && (operandAddr[2:0] == exec_pkg::PORT_B_SEL) && (operandAddr[6:3] == 4'h0);
   assign loadC = isDir && (operandAddr[2:0] == exec_pkg::PORT_C_SEL) && (operandAddr[6:3] == 4'h0);

   // Accumulator
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         acc_r <= exec_pkg::ACC_RESET;
      else if (opValid && !toMem && !isDir)
         acc_r <= result;
   end

   // Zero flag, only XOR ops touch it
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         zeroFlag_r <= 1'b0;
      else if (opValid && (opCode == exec_pkg::XOR_IMMEDIATE_OP || opCode == exec_pkg::XOR_MEMORY_OP))
         zeroFlag_r <= (result == 8'h00);
   end

   // Memory write back
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         memWe_r    <= 1'b0;
         memWaddr_r <= 7'h00;
         memWdata_r <= 8'h00;
      end
      else
      begin
         memWe_r <= opValid && toMem;
         if (opValid && toMem)
         begin
            memWaddr_r <= operandAddr;
            memWdata_r <= result;
         end
      end
   end

   dir_reg #(.WIDTH(8), .RESET(exec_pkg::DIR_RESET)) u_dir_a
   (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .load    (loadA),
      .din     (acc_r),
      .q       (port_a_direction)
   );
   dir_reg #(.WIDTH(8), .RESET(exec_pkg::DIR_RESET)) u_dir_b
   (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .load    (loadB),
      .din     (acc_r),
      .q       (port_b_direction)
   );
   dir_reg #(.WIDTH(8), .RESET(exec_pkg::DIR_RESET)) u_dir_c
   (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .load    (loadC),
      .din     (acc_r),
      .q       (port_c_direction)
   );

   property p_swap;
      @(posedge clk_sys) disable iff (!resetn)
      (opValid && opCode == exec_pkg::NIBBLE_EXCHANGE_OP && destSel)
      |=> memWe_r && memWdata_r == {$past(memRdata[3:0]), $past(memRdata[7:4])}
          && memWaddr_r == $past(operandAddr) && $stable(acc_r);
   endproperty
   a_swap: assert property (p_swap) else $error("nibble exchange result wrong");

   property p_swap_flags;
      @(posedge clk_sys) disable iff (!resetn)
      (opValid && opCode == exec_pkg::NIBBLE_EXCHANGE_OP) |=> $stable(zeroFlag_r);
   endproperty
   a_swap_flags: assert property (p_swap_flags) else $error("nibble exchange changed flag");

   property p_dest_acc;
      @(posedge clk_sys) disable iff (!resetn)
      (opValid && opCode == exec_pkg::XOR_MEMORY_OP && destSel == exec_pkg::DEST_ACC)
      |=> !memWe_r && acc_r == ($past(acc_r) ^ $past(memRdata));
   endproperty
   a_dest_acc: assert property (p_dest_acc) else $error("destination 0 not to accumulator");

   property p_swap_acc;
      @(posedge clk_sys) disable iff (!resetn)
      (opValid && opCode == exec_pkg::NIBBLE_EXCHANGE_OP && destSel == exec_pkg::DEST_ACC)
      |=> !memWe_r && acc_r == {$past(memRdata[3:0]), $past(memRdata[7:4])};
   endproperty
   a_swap_acc: assert property (p_swap_acc) else $error("nibble exchange not to accumulator");

   property p_dest_mem;
      @(posedge clk_sys) disable iff (!resetn)
      (opValid && opCode == exec_pkg::XOR_MEMORY_OP && destSel)
      |=> memWe_r && memWaddr_r == $past(operandAddr) && $stable(acc_r);
   endproperty
   a_dest_mem: assert property (p_dest_mem) else $error("destination 1 not to memory");

   property p_xor_immediate_op;
      @(posedge clk_sys) disable iff (!resetn)
      (opValid && opCode == exec_pkg::XOR_IMMEDIATE_OP)
      |=> acc_r == ($past(acc_r) ^ $past(literal)) && !memWe_r;
   endproperty
   a_xor_immediate_op: assert property (p_xor_immediate_op) else $error("xor immediate wrong");

   property p_xor_memory_op;
      @(posedge clk_sys) disable iff (!resetn)
      (opValid && opCode == exec_pkg::XOR_MEMORY_OP && destSel)
      |=> memWdata_r == ($past(acc_r) ^ $past(memRdata));
   endproperty
   a_xor_memory_op: assert property (p_xor_memory_op) else $error("xor memory wrong");

   property p_dir;
      @(posedge clk_sys) disable iff (!resetn)
      (opValid && opCode == exec_pkg::PORT_DIRECTION_LOAD_OP && operandAddr == 7'h06)
      |=> port_b_direction == $past(acc_r) && $stable(zeroFlag_r) && $stable(port_a_direction);
   endproperty
   a_dir: assert property (p_dir) else $error("direction load wrong");

   property p_zero;
      @(posedge clk_sys) disable iff (!resetn)
      (opValid && opCode == exec_pkg::XOR_IMMEDIATE_OP)
      |=> zeroFlag_r == (($past(acc_r) ^ $past(literal)) == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");

   property p_zero_mem;
      @(posedge clk_sys) disable iff (!resetn)
      (opValid && opCode == exec_pkg::XOR_MEMORY_OP)
      |=> zeroFlag_r == (($past(acc_r) ^ $past(memRdata)) == 8'h00);
   endproperty
   a_zero_mem: assert property (p_zero_mem) else $error("zero flag wrong after xor memory");

   // Only the selected direction register may take the accumulator
   property p_dir_sel;
      @(posedge clk_sys) disable iff (!resetn)
      (opValid && opCode == exec_pkg::PORT_DIRECTION_LOAD_OP)
      |=> port_a_direction == (($past(operandAddr) == 7'h05) ? $past(acc_r) : $past(port_a_direction))
          && port_b_direction == (($past(operandAddr) == 7'h06) ? $past(acc_r) : $past(port_b_direction))
          && port_c_direction == (($past(operandAddr) == 7'h07) ? $past(acc_r) : $past(port_c_direction))
          && $stable(acc_r) && $stable(zeroFlag_r) && !memWe_r;
   endproperty
   a_dir_sel: assert property (p_dir_sel) else $error("direction select wrong");

   // No instruction, no change of accumulator, zero flag or port A direction and no write strobe
   property p_idle;
      @(posedge clk_sys) disable iff (!resetn)
      !opValid |=> !memWe_r && $stable(acc_r) && $stable(zeroFlag_r) && $stable(port_a_direction);
   endproperty
   a_idle: assert property (p_idle) else $error("state changed without instruction");

   c_swap_mem: cover property (@(posedge clk_sys) opValid && opCode == exec_pkg::NIBBLE_EXCHANGE_OP && destSel);
   c_zero_set: cover property (@(posedge clk_sys) opValid && opCode == exec_pkg::XOR_IMMEDIATE_OP && result == 8'h00);
   c_dir_c:    cover property (@(posedge clk_sys) loadC);
   c_dir_none: cover property (@(posedge clk_sys) isDir && !loadA && !loadB && !loadC);
   c_idle:     cover property (@(posedge clk_sys) resetn && !opValid);
endmodule

// ---- nibble_swap_xor_port_direction_load_op_exec_bench.sv ----
`timescale 1ns/10ps
module nibble_swap_xor_port_direction_load_op_exec_bench;
   typedef struct packed
   {
      logic [1:0] op;
      logic [6:0] a;
      logic       d;
      logic [7:0] k;
      logic [7:0] acc;
      logic       z;
      logic       we;
      logic [7:0] wd;
   } row_type;
   logic clk_sys = 0, resetn = 0, opValid = 0, destSel = 0, memWe_r, zeroFlag_r;
   exec_pkg::op_type opCode = exec_pkg::op_type'(2'h0);
   logic [6:0] operandAddr = 7'h00, memWaddr_r;
   logic [7:0] literal = 8'h00, memRdata, memWdata_r, acc_r, dirA, dirB, dirC;
   int miscompares = 0, checksDone = 0, cycles = 0;
   row_type rows [11] = '{
      {2'h1,7'h00,1'b0,8'ha5,8'ha5,1'b0,1'b0,8'h00}, {2'h1,7'h00,1'b0,8'ha5,8'h00,1'b1,1'b0,8'h00},
      {2'h2,7'h3c,1'b0,8'h00,8'h3c,1'b0,1'b0,8'h00}, {2'h0,7'h12,1'b1,8'h00,8'h3c,1'b0,1'b1,8'h21},
      {2'h1,7'h00,1'b0,8'h00,8'h3c,1'b0,1'b0,8'h00}, {2'h0,7'h12,1'b0,8'h00,8'h12,1'b0,1'b0,8'h00},
      {2'h2,7'h12,1'b1,8'h00,8'h12,1'b0,1'b1,8'h33}, {2'h2,7'h7f,1'b0,8'h00,8'h6d,1'b0,1'b0,8'h00},
      {2'h1,7'h00,1'b0,8'h6d,8'h00,1'b1,1'b0,8'h00}, {2'h0,7'h01,1'b0,8'h00,8'h10,1'b1,1'b0,8'h00},
      {2'h2,7'h10,1'b1,8'h00,8'h10,1'b1,1'b1,8'h00}};

   nibble_swap_xor_port_direction_load_op_exec uut (.clk_sys(clk_sys), .resetn(resetn), .opValid(opValid), .opCode(opCode),
      .operandAddr(operandAddr), .destSel(destSel), .literal(literal), .memRdata(memRdata),
      .memWe_r(memWe_r), .memWaddr_r(memWaddr_r), .memWdata_r(memWdata_r), .acc_r(acc_r),
      .zeroFlag_r(zeroFlag_r), .port_a_direction(dirA), .port_b_direction(dirB), .port_c_direction(dirC));
   mem_model dataMem (.clk_sys(clk_sys), .rdAddr(operandAddr), .rdData(memRdata), .we(memWe_r),
      .wAddr(memWaddr_r), .wData(memWdata_r));

   initial
   begin
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One instruction per cycle; valid stays up so back-to-back issue is seamless
   task automatic issue(input logic [1:0] op, input logic [6:0] a, input logic d, input logic [7:0] k);
      opValid = 1'b1;
      opCode = exec_pkg::op_type'(op);
      operandAddr = a;
      destSel = d;
      literal = k;
      @(posedge clk_sys);
      #1;
   endtask

   task end_sim;
      $display("checks %0d mismatches %0d", checksDone, miscompares);
      if (miscompares == 0 && checksDone > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 200)
      begin
         miscompares++;
         end_sim;
      end
   end

   initial
   begin
      repeat (2) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      for (int i = 0; i < 11; i++)
      begin
         issue(rows[i].op, rows[i].a, rows[i].d, rows[i].k);
         check(acc_r, rows[i].acc);
         check(zeroFlag_r, rows[i].z);
         check(memWe_r, rows[i].we);
         check({dirA, dirB, dirC}, 24'hffffff);
         if (rows[i].we)
         begin
            check(memWdata_r, rows[i].wd);
            check(memWaddr_r, rows[i].a);
         end
      end
      issue(2'h3, 7'h05, 1'b0, 8'h00);
      check({dirA, dirB, dirC, zeroFlag_r}, {24'h10ffff, 1'b1});
      issue(2'h1, 7'h00, 1'b0, 8'h33);
      issue(2'h3, 7'h06, 1'b0, 8'h00);
      issue(2'h1, 7'h00, 1'b0, 8'h77);
      issue(2'h3, 7'h07, 1'b0, 8'h00);
      check({dirA, dirB, dirC}, 24'h102354);
      // Operand outside 5..7 must leave every direction register alone
      issue(2'h3, 7'h04, 1'b0, 8'h00);
      check({dirA, dirB, dirC, acc_r}, 32'h10235454);
      // Idle cycle with a memory-writing opcode left on the bus
      opValid = 1'b0;
      opCode = exec_pkg::XOR_MEMORY_OP;
      operandAddr = 7'h20;
      destSel = 1'b1;
      @(posedge clk_sys);
      #1;
      check({acc_r, 6'h00, zeroFlag_r, memWe_r}, {8'h54, 8'h00});
      // Destination bit is ignored by xor immediate
      issue(2'h1, 7'h00, 1'b1, 8'h54);
      check(acc_r, 8'h00);
      check({zeroFlag_r, memWe_r}, 2'h2);
      // Low bits select a port but upper bits are set: refused
      issue(2'h3, 7'h0d, 1'b0, 8'h00);
      check({dirA, dirB, dirC, acc_r}, 32'h10235400);
      opValid = 1'b0;
      resetn = 1'b0;
      @(posedge clk_sys);
      #1;
      check({dirA, dirB, dirC, acc_r}, 32'hffffff00);
      check({zeroFlag_r, memWe_r}, 2'h0);
      // First instruction right after release of the mid-run reset
      resetn = 1'b1;
      issue(2'h2, 7'h05, 1'b1, 8'h00);
      check({memWe_r, memWaddr_r, memWdata_r, acc_r}, {1'b1, 7'h05, 8'h05, 8'h00});
      check(zeroFlag_r, 1'b0);
      opValid = 1'b0;
      @(posedge clk_sys);
      #1;
      check(memWe_r, 1'b0);
      end_sim;
   end
endmodule
